// *** rtl/port_cfg_defines.svh ***
// Offsets, field positions and the command bit reset value for the switch port
// identification and command words. Definitions only.
`ifndef PORT_CFG_DEFINES_SVH
`define PORT_CFG_DEFINES_SVH

// Byte offsets of the configuration dwords
`define ID_DWORD_OFFSET 8'h00
`define CMD_DWORD_OFFSET 8'h04

// Command word field positions
`define CMD_IO_EN_POS 0
`define CMD_MEM_EN_POS 1
`define CMD_BUS_MASTER_POS 2
`define CMD_PARITY_RESP_POS 6
`define CMD_SYS_ERR_POS 8
`define CMD_INTX_DIS_POS 10

// Reset value of every writable command bit
`define CMD_BIT_RESET 1'b0

// Identifier override selector codes
`define ID_SEL_MAKER 1'b0
`define ID_SEL_PART 1'b1

`endif

// *** rtl/port_cfg_pkg.sv ***
// Types shared by the identification and command register block.
// Assumes the defines header is compiled alongside.
package port_cfg_pkg;

  // Entire state of the block, registered as one word
  typedef struct packed {
    logic [15:0] maker_id;     // Vendor identifier value
    logic [15:0] part_id;      // Device identifier value
    logic io_en;               // I/O decode enable
    logic mem_en;              // Memory decode enable
    logic bus_master_en;       // Upstream forwarding enable
    logic parity_resp_en;      // Parity error response enable
    logic sys_err_en;          // Error message reporting enable
    logic intx_dis;            // Own INTx disable
    logic [31:0] rdata;        // Read return data
    logic rvalid;              // Read return strobe
    logic io_claim;            // Primary I/O request accepted
    logic mem_claim;           // Primary memory request accepted
    logic up_fwd;              // Downstream request sent upstream
    logic dn_ur;               // Downstream request unsupported
    logic dn_ur_cpl;           // UR completion to be returned
    logic parity_act;          // Parity error acted upon
    logic fatal_msg;           // Fatal error message to root
    logic nonfatal_msg;        // Non-fatal error message to root
    logic intx_assert;         // Own INTx asserted
    logic intx_fwd;            // Downstream INTx passed on
  } cfg_state_s;

endpackage : port_cfg_pkg

// *** rtl/switch_port_config_id_command.sv ***
// Identification and command words of a switch port bridge header.
// Assumes a single-cycle configuration access port and same-clock event
// sources from the port's transaction logic; no synchronisers needed.
// Requests are taken on one edge; read data returns one cycle later.
// Identifier defaults are parameters; an override sticks until reset.
`timescale 1ns/1ps
`include "port_cfg_defines.svh"

module switch_port_config_id_command
  import port_cfg_pkg::*;
#(
  parameter logic [15:0] MAKER_ID_DEFAULT = 16'h1a2b, // Arbitrary value
  parameter logic [15:0] PART_ID_DEFAULT = 16'h3c4d   // Arbitrary value
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Configuration access
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // Identifier override from SMBus or EEPROM loader
  input wire logic id_load_in,
  input wire logic id_load_sel_in,
  input wire logic [15:0] id_load_data_in,
  // Primary side requests
  input wire logic pri_io_req_in,
  input wire logic pri_mem_req_in,
  output logic pri_io_claim_out,
  output logic pri_mem_claim_out,
  // Requests arriving at the downstream port
  input wire logic dn_req_in,
  input wire logic dn_req_nonposted_in,
  output logic up_fwd_out,
  output logic dn_ur_out,
  output logic dn_ur_cpl_out,
  // Error sources
  input wire logic parity_err_in,
  input wire logic fatal_err_in,
  input wire logic nonfatal_err_in,
  output logic parity_action_out,
  output logic fatal_msg_out,
  output logic nonfatal_msg_out,
  // Interrupts
  input wire logic own_intx_in,
  input wire logic dn_intx_in,
  output logic intx_assert_out,
  output logic intx_fwd_out,
  // Command bits for the port datapath
  output logic io_en_out,
  output logic mem_en_out,
  output logic bus_master_en_out
);

  // All state lives in one struct, so every output is a flop bit
  // and the reset value is set in one place
  cfg_state_s state_ff;   // Registered state
  cfg_state_s nxt_state;  // Next state

  // Merge one byte lane of write data into an old byte
  // Lanes without their enable keep the old byte
  function automatic logic [7:0] merge_byte(input logic [7:0] old_b,
                                            input logic [7:0] new_b,
                                            input logic en);
    merge_byte = en ? new_b : old_b;
  endfunction : merge_byte

  // Assemble the command word as software reads it
  // Legacy and reserved positions are never stored, so they cannot
  // read back as anything but zero
  function automatic logic [15:0] cmd_word(input cfg_state_s s);
    logic [15:0] w;
    w = 16'h0000;
    w[`CMD_IO_EN_POS] = s.io_en;
    w[`CMD_MEM_EN_POS] = s.mem_en;
    w[`CMD_BUS_MASTER_POS] = s.bus_master_en;
    w[`CMD_PARITY_RESP_POS] = s.parity_resp_en;
    w[`CMD_SYS_ERR_POS] = s.sys_err_en;
    w[`CMD_INTX_DIS_POS] = s.intx_dis;
    cmd_word = w;
  endfunction : cmd_word

  // Next-state logic for registers, reads and event gating
  always_comb begin
    logic [15:0] cmd_new; // Command after the byte-lane merge
    logic [15:0] cmd_old; // Command as it stands before this edge
    cmd_new = 16'h0000;
    // Command word as software would read it now
    cmd_old = cmd_word(state_ff);
    // Hold everything by default
    nxt_state = state_ff;

    // Strobes last one cycle unless re-raised
    // Read data is zero outside its one-cycle strobe
    nxt_state.rvalid = 1'b0;
    nxt_state.rdata = 32'h0000_0000;

    // Identifier override path; config writes never reach these
    // Loads come from the SMBus or the EEPROM loader, one word per strobe
    if (id_load_in) begin
      if (id_load_sel_in == `ID_SEL_MAKER) begin
        nxt_state.maker_id = id_load_data_in;
      end else begin
        nxt_state.part_id = id_load_data_in;
      end
    end

    // Command write; only the defined bits are kept
    // Byte lanes merge into the stored word first, then each live
    // bit is picked out; a write with no lanes set changes nothing
    // Writes to the identifier dword have no path at all
    if (cfg_wr_in && cfg_addr_in == `CMD_DWORD_OFFSET) begin
      cmd_new[7:0] = merge_byte(cmd_old[7:0], cfg_wdata_in[7:0], cfg_be_in[0]);
      cmd_new[15:8] = merge_byte(cmd_old[15:8], cfg_wdata_in[15:8], cfg_be_in[1]);
      nxt_state.io_en = cmd_new[`CMD_IO_EN_POS];
      nxt_state.mem_en = cmd_new[`CMD_MEM_EN_POS];
      nxt_state.bus_master_en = cmd_new[`CMD_BUS_MASTER_POS];
      nxt_state.parity_resp_en = cmd_new[`CMD_PARITY_RESP_POS];
      nxt_state.sys_err_en = cmd_new[`CMD_SYS_ERR_POS];
      nxt_state.intx_dis = cmd_new[`CMD_INTX_DIS_POS];
      // Bits 3,4,5,7,9 and 15:11 are dropped here
    end

    // Read return one cycle after the request
    // A read in the same cycle as a write returns the old value,
    // since both decode from the registered state
    if (cfg_rd_in) begin
      nxt_state.rvalid = 1'b1;
      case (cfg_addr_in)
        // Part identifier high, maker identifier low
        `ID_DWORD_OFFSET: begin
          nxt_state.rdata = {state_ff.part_id, state_ff.maker_id};
        end
        `CMD_DWORD_OFFSET: begin
          // Status half is outside this block and reads zero
          nxt_state.rdata = {16'h0000, cmd_old};
        end
        default: begin
          nxt_state.rdata = 32'h0000_0000; // Unmapped reads zero
        end
      endcase
    end

    // Events use the enables as they stood before this edge
    // A command write in the same cycle only acts from the next request;
    // this keeps the gates free of a write-to-use path
    // Primary side decode
    nxt_state.io_claim = pri_io_req_in & state_ff.io_en;
    nxt_state.mem_claim = pri_mem_req_in & state_ff.mem_en;
    // Downstream requests go either upstream or back as unsupported
    nxt_state.up_fwd = dn_req_in & state_ff.bus_master_en;
    nxt_state.dn_ur = dn_req_in & ~state_ff.bus_master_en;
    // Posted requests get no completion
    nxt_state.dn_ur_cpl = dn_req_in & dn_req_nonposted_in & ~state_ff.bus_master_en;
    // Parity errors may be dropped when the response is off
    nxt_state.parity_act = parity_err_in & state_ff.parity_resp_en;
    // Both error kinds share one reporting enable
    nxt_state.fatal_msg = fatal_err_in & state_ff.sys_err_en;
    nxt_state.nonfatal_msg = nonfatal_err_in & state_ff.sys_err_en;
    // Forwarding ignores the disable bit by design
    nxt_state.intx_assert = own_intx_in & ~state_ff.intx_dis;
    nxt_state.intx_fwd = dn_intx_in;

    // Synchronous reset to the power-on defaults
    // Reset wins over every write and load in the same cycle
    // Any earlier identifier override is lost here
    if (!rst_n_in) begin
      nxt_state = '0;
      nxt_state.maker_id = MAKER_ID_DEFAULT;
      nxt_state.part_id = PART_ID_DEFAULT;
      nxt_state.io_en = `CMD_BIT_RESET;
      nxt_state.mem_en = `CMD_BIT_RESET;
      nxt_state.bus_master_en = `CMD_BIT_RESET;
      nxt_state.parity_resp_en = `CMD_BIT_RESET;
      nxt_state.sys_err_en = `CMD_BIT_RESET;
      nxt_state.intx_dis = `CMD_BIT_RESET;
    end
  end

  // Single state register
  // No reset branch here; the reset lives in the next-state logic
  always_ff @(posedge mclk_in) begin
    state_ff <= nxt_state;
  end

  // Outputs straight from the state register
  // Read return
  assign cfg_rdata_out = state_ff.rdata;
  assign cfg_rvalid_out = state_ff.rvalid;

  // Primary side claims
  assign pri_io_claim_out = state_ff.io_claim;
  assign pri_mem_claim_out = state_ff.mem_claim;

  // Downstream decisions
  assign up_fwd_out = state_ff.up_fwd;
  assign dn_ur_out = state_ff.dn_ur;
  assign dn_ur_cpl_out = state_ff.dn_ur_cpl;

  // Error actions
  assign parity_action_out = state_ff.parity_act;
  assign fatal_msg_out = state_ff.fatal_msg;
  assign nonfatal_msg_out = state_ff.nonfatal_msg;

  // Interrupts
  assign intx_assert_out = state_ff.intx_assert;
  assign intx_fwd_out = state_ff.intx_fwd;

  // Command bits for the datapath
  assign io_en_out = state_ff.io_en;
  assign mem_en_out = state_ff.mem_en;
  assign bus_master_en_out = state_ff.bus_master_en;

endmodule : switch_port_config_id_command

// *** tb/port_cfg_checker.sv ***
// Concurrent checks on the id/command block ports.
// Assumes binding into the block; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module port_cfg_checker (
  input logic mclk_in,
  input logic rst_n_in,
  input logic cfg_rd_in,
  input logic [7:0] cfg_addr_in,
  input logic [31:0] cfg_rdata_out,
  input logic cfg_rvalid_out,
  input logic pri_io_req_in,
  input logic pri_mem_req_in,
  input logic pri_io_claim_out,
  input logic pri_mem_claim_out,
  input logic dn_req_in,
  input logic dn_req_nonposted_in,
  input logic up_fwd_out,
  input logic dn_ur_cpl_out,
  input logic fatal_err_in,
  input logic nonfatal_err_in,
  input logic fatal_msg_out,
  input logic nonfatal_msg_out,
  input logic dn_intx_in,
  input logic intx_fwd_out,
  input logic io_en_out,
  input logic mem_en_out,
  input logic bus_master_en_out
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Claims follow the enable as it stood before the request edge
  property p_io; 1 |=> pri_io_claim_out == $past(pri_io_req_in && io_en_out); endproperty
  a_io: assert property (p_io) else $error("io claim wrong");
  property p_mem; 1 |=> pri_mem_claim_out == $past(pri_mem_req_in && mem_en_out); endproperty
  a_mem: assert property (p_mem) else $error("mem claim wrong");
  property p_fwd; 1 |=> up_fwd_out == $past(dn_req_in && bus_master_en_out); endproperty
  a_fwd: assert property (p_fwd) else $error("upstream forward wrong");
  // UR completion only for non-posted requests while mastering is off
  property p_ur;
    1 |=> dn_ur_cpl_out == $past(dn_req_in && dn_req_nonposted_in && !bus_master_en_out);
  endproperty
  a_ur: assert property (p_ur) else $error("ur completion wrong");
  // Both error kinds share one enable, so paired inputs give paired outputs
  property p_err; fatal_err_in && nonfatal_err_in |=> fatal_msg_out == nonfatal_msg_out; endproperty
  a_err: assert property (p_err) else $error("error report pair differs");
  property p_ifw; 1 |=> intx_fwd_out == $past(dn_intx_in); endproperty
  a_ifw: assert property (p_ifw) else $error("intx forward gated");
  property p_rv; 1 |=> cfg_rvalid_out == $past(cfg_rd_in); endproperty
  a_rv: assert property (p_rv) else $error("read return timing");
  // Fixed-zero bits read zero, bits 2:0 read the old command enables
  property p_cmd;
    cfg_rd_in && cfg_addr_in == 8'h04 |=> (cfg_rdata_out & 32'hfffffab8) == 32'h0 &&
      cfg_rdata_out[2:0] == $past({bus_master_en_out, mem_en_out, io_en_out});
  endproperty
  a_cmd: assert property (p_cmd) else $error("command read wrong");
  c_fwd: cover property (up_fwd_out);
  c_ur: cover property (dn_ur_cpl_out);
  c_cmd: cover property (cfg_rd_in && cfg_addr_in == 8'h04 && io_en_out);
endmodule : port_cfg_checker

bind switch_port_config_id_command port_cfg_checker u_chk (.*);

// *** tb/link_model.sv ***
// Far side: root complex and downstream devices raising events.
// Assumes the bench feeds random bits updated on rising edges.
`timescale 1ns/1ps
module link_model (
  input logic mclk_in,
  input logic [8:0] rnd_in,
  output logic [8:0] ev_out
);
  // New requests, errors and levels every edge, back to back
  // Unknown only up to the first edge, which falls inside reset
  always @(posedge mclk_in) begin
    ev_out <= rnd_in;
  end
endmodule : link_model

// *** tb/testbench.sv ***
// Self-checking bench for the id/command block.
// Assumes the bound checker and the link model for event traffic.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  localparam logic [15:0] MK = 16'h5e11; // Arbitrary value
  localparam logic [15:0] PT = 16'h7a02; // Arbitrary value
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cfg_wr_in = 1'b0, cfg_rd_in = 1'b0, id_load_in = 1'b0, id_load_sel_in = 1'b0;
  logic [7:0] cfg_addr_in = 8'h00;
  logic [3:0] cfg_be_in = 4'h0;
  logic [31:0] cfg_wdata_in = 32'h0, cfg_rdata_out, rnd = 32'hfcf4, exp_r;
  logic [15:0] id_load_data_in = 16'h0, cmd, maker, part;
  logic [8:0] ev, rnd_ev = 9'h0; // Event inputs, model feed
  wire [9:0] evo; // Event outputs, one port per bit
  logic [9:0] exp_e; // Expected event outputs
  logic cfg_rvalid_out, io_en_out, mem_en_out, bus_master_en_out;
  logic [9:0] evq[$];
  logic [31:0] rdq[$];
  int failures = 0, n_tests = 0;
  always #5 mclk_in = ~mclk_in;
  switch_port_config_id_command #(.MAKER_ID_DEFAULT(MK), .PART_ID_DEFAULT(PT)) u_dut (.*,
    .pri_io_req_in(ev[8]), .pri_mem_req_in(ev[7]), .dn_req_in(ev[6]),
    .dn_req_nonposted_in(ev[5]), .parity_err_in(ev[4]), .fatal_err_in(ev[3]),
    .nonfatal_err_in(ev[2]), .own_intx_in(ev[1]), .dn_intx_in(ev[0]),
    .pri_io_claim_out(evo[9]), .pri_mem_claim_out(evo[8]), .up_fwd_out(evo[7]),
    .dn_ur_out(evo[6]), .dn_ur_cpl_out(evo[5]), .parity_action_out(evo[4]),
    .fatal_msg_out(evo[3]), .nonfatal_msg_out(evo[2]), .intx_assert_out(evo[1]),
    .intx_fwd_out(evo[0]));
  link_model u_link (.mclk_in(mclk_in), .rnd_in(rnd_ev), .ev_out(ev));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic test_done;
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // Note what each taken request should give one edge later
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      evq.push_back(10'h0);
      {cmd, maker, part} <= {16'h0, MK, PT};
    end else begin
      evq.push_back({ev[8] & cmd[0], ev[7] & cmd[1], ev[6] & cmd[2], ev[6] & !cmd[2],
        ev[6] & ev[5] & !cmd[2], ev[4] & cmd[6], ev[3] & cmd[8], ev[2] & cmd[8],
        ev[1] & !cmd[10], ev[0]});
      if (cfg_rd_in) rdq.push_back(cfg_addr_in == 8'h00 ? {part, maker} :
        cfg_addr_in == 8'h04 ? {16'h0, cmd} : 32'h0);
      // Only the six live bits can be written
      if (cfg_wr_in && cfg_addr_in == 8'h04) cmd <= 16'h0547 & {cfg_be_in[1] ?
        cfg_wdata_in[15:8] : cmd[15:8], cfg_be_in[0] ? cfg_wdata_in[7:0] : cmd[7:0]};
      if (id_load_in) begin
        if (id_load_sel_in) part <= id_load_data_in;
        else maker <= id_load_data_in;
      end
    end
  end
  // Compare after the edge's updates have landed
  always @(negedge mclk_in) begin
    if (evq.size() > 0) begin
      exp_e = evq.pop_front();
      `CHK("events", exp_e, evo)
      `CHK("enables", cmd[2:0], {bus_master_en_out, mem_en_out, io_en_out})
      `CHK("rvalid", rdq.size() > 0, cfg_rvalid_out)
      exp_r = rdq.size() > 0 ? rdq.pop_front() : 32'h0;
      `CHK("rdata", exp_r, cfg_rdata_out)
    end
  end
  // Random traffic: reads, writes, loads and one mid-run reset
  initial begin
    repeat (3) @(posedge mclk_in);
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk_in);
      rnd = xs(rnd);
      rst_n_in <= i != 1500;
      rnd_ev <= rnd[8:0];
      cfg_wr_in <= rnd[9] & rnd[10];
      cfg_rd_in <= rnd[11];
      cfg_addr_in <= rnd[13] ? rnd[31:24] : {5'h0, rnd[12], 2'h0};
      cfg_be_in <= rnd[17:14];
      cfg_wdata_in <= {rnd[15:0], rnd[31:16]};
      id_load_in <= rnd[18] & rnd[19] & rnd[20];
      id_load_sel_in <= rnd[21];
      id_load_data_in <= rnd[31:16];
    end
    repeat (3) @(posedge mclk_in);
    test_done;
  end
  // Hang guard, well past the planned run
  initial begin
    #40000;
    failures++;
    test_done;
  end
endmodule : testbench
